/* design/uts_sequencer.sv */
// Purpose: Measurement sequencer of an ultrasonic time-of-flight front end.
// Assumes: i_clk is the reference clock; registers written on a parallel port.
// Notes: Comparator events arrive as asynchronous levels and are synchronised.
`timescale 1ns/1ps
module uts_sequencer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_trigger,
  input wire logic i_channel_pin,
  input wire logic i_threshold_event,
  input wire logic i_zero_cross,
  input wire logic i_reg_write,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_transmit_port_one,
  output logic o_transmit_port_two,
  output logic o_receive_select_two,
  output logic o_start,
  output logic o_stop,
  output logic o_fault_pin_n
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic en_s; // Synchronised enable pin.
  logic trig_s; // Synchronised trigger pin.
  logic chpin_s; // Synchronised channel pin.
  logic thld_s; // Synchronised threshold comparator.
  logic zc_s; // Synchronised zero-cross comparator.
  logic pwr_done; // Rises once the pin synchronisers hold settled levels.

  uts_sync u_sync_en (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_enable), .o_sync(en_s));
  uts_sync u_sync_trig (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_trigger), .o_sync(trig_s));
  uts_sync u_sync_ch (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_channel_pin), .o_sync(chpin_s));
  uts_sync u_sync_th (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_threshold_event), .o_sync(thld_s));
  uts_sync u_sync_zc (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_zero_cross), .o_sync(zc_s));
  // Same latency as the pins, so power-up never decides on a reset level of the enable.
  uts_sync u_sync_pwr (.i_clk(i_clk), .i_rst(i_rst), .i_async(1'b1), .o_sync(pwr_done));

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] transmit_config; // Burst divider [7:5], pulse count [4:0].
  logic [7:0] meas_config; // Mode [1:0], chan [2], swap [3], stops [6:4], echo [7].
  logic [7:0] shape_config; // Flip pos [4:0], damp [5], edge [6], base div [7].
  logic [7:0] avg_config; // Pin control [7], average count [6:0].
  logic [1:0] fault_flags; // Missing stops [1], timeout [0].

  wire [2:0] burst_div = transmit_config[7:uts_pkg::BURST_DIV_LSB];
  wire [4:0] pulse_count = transmit_config[4:0];
  wire [1:0] mode = meas_config[1:0];
  wire channel_select = meas_config[2];
  wire auto_direction_swap = meas_config[3];
  wire [2:0] expected_stop_count = meas_config[6:4];
  wire echo_mode_select = meas_config[7];
  wire [4:0] phase_flip_position = shape_config[4:0];
  wire damping = shape_config[5];
  wire trigger_edge_select = shape_config[6];
  wire base_period_divider = shape_config[7];
  wire pin_channel_control = avg_config[7];
  wire [6:0] average_count = avg_config[6:0];

  // Write strobes per register.
  wire wr_tx = i_reg_write && (i_reg_addr == uts_pkg::TRANSMIT_CONFIG_ADDR);
  wire wr_meas = i_reg_write && (i_reg_addr == uts_pkg::MEAS_CONFIG_ADDR);
  wire wr_shape = i_reg_write && (i_reg_addr == uts_pkg::SHAPE_CONFIG_ADDR);
  wire wr_avg = i_reg_write && (i_reg_addr == 4'h4);
  wire wr_fault = i_reg_write && (i_reg_addr == uts_pkg::FAULT_ADDR);
  wire fsm_soft_reset = wr_fault && i_reg_wdata[uts_pkg::FSM_RESET_BIT];
  wire fault_clear = wr_fault && i_reg_wdata[uts_pkg::FAULT_CLEAR_BIT];

  uts_pkg::uts_state_e state;
  uts_pkg::uts_state_e next_state;
  logic [6:0] avg_done; // measurements completed in this direction.
  logic swapped; // Averaging has moved to the other direction.

  // Configuration registers keep their value until software rewrites them.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      transmit_config <= uts_pkg::TRANSMIT_CONFIG_RST;
      meas_config <= uts_pkg::MEAS_CONFIG_RST;
      shape_config <= uts_pkg::SHAPE_CONFIG_RST;
      avg_config <= 8'h00;
    end else begin
      if (wr_tx) transmit_config <= i_reg_wdata;
      if (wr_meas) meas_config <= i_reg_wdata;
      if (wr_shape) shape_config <= i_reg_wdata;
      if (wr_avg) avg_config <= i_reg_wdata;
    end
  end

  // Read data selection; unmapped indices read zero.
  wire [7:0] rd_sel = (i_reg_addr == uts_pkg::TRANSMIT_CONFIG_ADDR) ? transmit_config :
                      (i_reg_addr == uts_pkg::MEAS_CONFIG_ADDR) ? meas_config :
                      (i_reg_addr == uts_pkg::SHAPE_CONFIG_ADDR) ? shape_config :
                      (i_reg_addr == 4'h4) ? avg_config :
                      (i_reg_addr == uts_pkg::FAULT_ADDR) ? {3'h0, state, fault_flags} : 8'h00;

  // Read data is registered so the output comes from a flip-flop.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_reg_rdata <= 8'h00;
    else o_reg_rdata <= rd_sel;
  end

  // ----------------------------------------------------------------
  // Period dividers
  // ----------------------------------------------------------------
  // base and burst dividers
  logic base_cnt; // Base period divides by 1 or 2.
  logic [7:0] burst_cnt; // Burst period divides by 2 to 256.
  wire base_tick = base_period_divider ? base_cnt : 1'b1;
  wire [7:0] burst_last = 8'((9'h2 << burst_div) - 9'h1);
  wire burst_tick = (burst_cnt >= burst_last);

  // Free running dividers keep the trigger-to-start delay phase dependent.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      base_cnt <= 1'b0;
      burst_cnt <= 8'h00;
    end else begin
      base_cnt <= ~base_cnt;
      burst_cnt <= burst_tick ? 8'h00 : burst_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Trigger edge and channel choice
  // ----------------------------------------------------------------
  logic trig_d; // Previous synchronised trigger level.
  wire trig_edge = trigger_edge_select ? (trig_d & ~trig_s) : (~trig_d & trig_s);
  wire abort = ~en_s | fsm_soft_reset;

  wire auto_dir = channel_select ^ (swapped & auto_direction_swap);
  wire active_ch = (mode == uts_pkg::MODE_2) ?
                   (pin_channel_control ? chpin_s : auto_dir) :
                   (pin_channel_control ? chpin_s : channel_select);
  wire rx_two = (mode == uts_pkg::MODE_0) ? ~active_ch : active_ch;

  // ----------------------------------------------------------------
  // Sequencing counters
  // ----------------------------------------------------------------
  logic [1:0] base_wait; // Base periods spent aligning.
  logic [1:0] burst_wait; // Burst periods spent aligning.
  logic [5:0] half_cnt; // Burst half periods emitted.
  logic [7:0] listen_cnt; // Burst periods spent listening.
  logic [2:0] stop_cnt; // Stop pulses issued.
  logic armed; // next zero crossing is qualified.
  logic zc_d; // Previous zero-cross level.
  logic tx_phase; // Current transmit drive level.

  wire zc_rise = zc_s & ~zc_d;
  wire flip_on = (phase_flip_position != uts_pkg::PHASE_FLIP_OFF);
  // The held half period at the flip merges two pulses, so the count needs no cut.
  wire [5:0] pulses_out = {1'b0, pulse_count};
  wire [5:0] half_total = 6'((pulses_out << 1) + {5'h0, damping});
  wire align_done = (base_wait == 2'(uts_pkg::START_BASE_PERIODS)) &&
                    (burst_wait == 2'(uts_pkg::START_BURST_PERIODS)) && burst_tick;
  wire burst_done = burst_tick && (half_cnt + 6'h1 >= half_total);
  wire all_stops = (stop_cnt == expected_stop_count);
  wire timeout = burst_tick && (listen_cnt == 8'(uts_pkg::LISTEN_BURST_PERIODS));
  wire stop_edge = armed && zc_rise && !o_stop && !all_stops;

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      uts_pkg::UTS_POWERUP: if (pwr_done) next_state = en_s ? uts_pkg::UTS_READY : uts_pkg::UTS_SLEEP;
      // sleep holds; a trigger with enable still starts
      uts_pkg::UTS_SLEEP: if (en_s && trig_edge) next_state = uts_pkg::UTS_ALIGN;
      uts_pkg::UTS_READY: if (trig_edge) next_state = uts_pkg::UTS_ALIGN;
      uts_pkg::UTS_ALIGN: if (align_done) next_state = uts_pkg::UTS_BURST;
      uts_pkg::UTS_BURST: if (burst_done) next_state = uts_pkg::UTS_LISTEN;
      uts_pkg::UTS_LISTEN: begin
        // modes 0 and 1 sleep after all stops; a timeout goes to ready in every mode
        if (all_stops && !o_stop) begin
          next_state = (mode == uts_pkg::MODE_2) ? uts_pkg::UTS_READY : uts_pkg::UTS_SLEEP;
        end else if (timeout) begin
          next_state = uts_pkg::UTS_READY;
        end
      end
      default: next_state = uts_pkg::UTS_SLEEP;
    endcase
    if (abort && state != uts_pkg::UTS_POWERUP) next_state = uts_pkg::UTS_SLEEP;
  end

  // State register; the reset pin aborts through i_rst.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) state <= uts_pkg::UTS_POWERUP;
    else state <= next_state;
  end

  // Alignment and burst counters, cleared whenever the state changes.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      base_wait <= 2'h0;
      burst_wait <= 2'h0;
      half_cnt <= 6'h0;
      listen_cnt <= 8'h00;
      trig_d <= 1'b0;
    end else begin
      trig_d <= trig_s;
      if (state != next_state) begin
        base_wait <= 2'h0;
        burst_wait <= 2'h0;
        half_cnt <= 6'h0;
        listen_cnt <= 8'h00;
      end else if (state == uts_pkg::UTS_ALIGN) begin
        if (base_tick && base_wait != 2'(uts_pkg::START_BASE_PERIODS)) base_wait <= base_wait + 2'h1;
        else if (base_wait == 2'(uts_pkg::START_BASE_PERIODS) && burst_tick &&
                 burst_wait != 2'(uts_pkg::START_BURST_PERIODS)) burst_wait <= burst_wait + 2'h1;
      end else if (state == uts_pkg::UTS_BURST && burst_tick) begin
        half_cnt <= half_cnt + 6'h1;
      end else if (state == uts_pkg::UTS_LISTEN && burst_tick) begin
        listen_cnt <= listen_cnt + 8'h01;
      end
    end
  end

  // Transmit drive: each burst tick is a half period; the flip repeats a level.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) tx_phase <= 1'b0;
    else if (state != uts_pkg::UTS_BURST || next_state != uts_pkg::UTS_BURST) tx_phase <= 1'b0;
    else if (burst_tick && !(flip_on && half_cnt == {phase_flip_position, 1'b0} - 6'h1))
      tx_phase <= ~tx_phase;
  end

  // Receive path: qualification and stop pulse generation.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      armed <= 1'b0;
      zc_d <= 1'b0;
      stop_cnt <= 3'h0;
      o_stop <= 1'b0;
    end else begin
      zc_d <= zc_s;
      if (state != uts_pkg::UTS_LISTEN) begin
        armed <= 1'b0;
        stop_cnt <= 3'h0;
        o_stop <= 1'b0;
      end else begin
        if (thld_s) armed <= 1'b1;
        else if (zc_rise && !echo_mode_select) armed <= 1'b0;
        if (stop_edge) begin
          o_stop <= 1'b1;
          stop_cnt <= stop_cnt + 3'h1;
        end else if (!echo_mode_select) begin
          o_stop <= 1'b0;
        end else if (zc_rise && !thld_s) begin
          o_stop <= 1'b0;
          armed <= 1'b0;
        end
      end
    end
  end

  // Fault flags: a new fault wins over a clear in the same cycle.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fault_flags <= 2'h0;
      o_fault_pin_n <= 1'b1;
    end else begin
      fault_flags[0] <= (state == uts_pkg::UTS_LISTEN && timeout) | (fault_flags[0] & ~fault_clear);
      fault_flags[1] <= (state == uts_pkg::UTS_LISTEN && timeout && !all_stops) |
                        (fault_flags[1] & ~fault_clear);
      o_fault_pin_n <= ~(|fault_flags);
    end
  end

  // Averaging progress per direction.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      avg_done <= 7'h00;
      swapped <= 1'b0;
    // clear count on reset or disable
    end else if (abort) begin
      avg_done <= 7'h00;
      swapped <= 1'b0;
    end else if (mode == uts_pkg::MODE_2 && average_count != 7'h00 &&
                 state == uts_pkg::UTS_LISTEN && next_state != uts_pkg::UTS_LISTEN) begin
      if (avg_done + 7'h01 >= average_count) begin
        avg_done <= 7'h00;
        swapped <= auto_direction_swap ? ~swapped : 1'b0;
      end else begin
        avg_done <= avg_done + 7'h01;
      end
    end
  end

  // Output pins registered from the sequencer state.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_transmit_port_one <= 1'b0;
      o_transmit_port_two <= 1'b0;
      o_receive_select_two <= 1'b0;
      o_start <= 1'b0;
    end else begin
      o_transmit_port_one <= tx_phase & ~active_ch;
      o_transmit_port_two <= tx_phase & active_ch;
      o_receive_select_two <= (state == uts_pkg::UTS_BURST) ? ~rx_two : rx_two;
      o_start <= (state == uts_pkg::UTS_ALIGN) && align_done;
    end
  end

endmodule : uts_sequencer

/* design/uts_sync.sv */
// Purpose: Two flip-flop synchroniser for one pin level.
// Assumes: The input is asynchronous to i_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module uts_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);

  // First stage, read by the second stage only.
  logic meta;

  // Two stages cut the chance of a metastable level reaching the logic.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : uts_sync

/* dv/tb_ultrasonic_tof_sequencer.sv */
// Purpose: Self-checking bench for the sequencer.
// Assumes: Register defaults except where a scenario writes them.
// Notes: Drivers queue expectations; a monitor compares them.
`timescale 1ns/1ps
module tb_ultrasonic_tof_sequencer;
  typedef struct {string what; int src; logic [7:0] exp; logic [7:0] mask;} uts_note_s;
  localparam logic [7:0] ST_SLEEP = 8'(uts_pkg::UTS_SLEEP) << 2; // State field in sleep.
  localparam logic [7:0] ST_READY = 8'(uts_pkg::UTS_READY) << 2; // State field in ready.
  localparam logic [7:0] TCFG [4] = '{8'h45, 8'h23, 8'h45, 8'h45};
  localparam logic [7:0] SCFG [4] = '{8'h1F, 8'h1F, 8'h03, 8'h1F};
  // Mode 0, mode 1 on channel one, mode 0, mode 2 on channel two.
  localparam logic [7:0] MCFG [4] = '{8'h10, 8'h11, 8'h10, 8'h16};
  localparam logic [7:0] NTX [4] = '{8'h05, 8'h03, 8'h04, 8'h00};
  localparam logic [7:0] HALF [4] = '{8'h08, 8'h04, 8'h08, 8'h00};
  localparam logic [7:0] TX2C [4] = '{8'h00, 8'h00, 8'h00, 8'h28};
  localparam logic [7:0] RXL [4] = '{8'h01, 8'h00, 8'h01, 8'h01};
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_enable = 1'b0, i_channel_pin = 1'b0, i_reg_write = 1'b0;
  logic [3:0] i_reg_addr = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
  logic falling = 1'b0, fire = 1'b0, echo = 1'b0, slow = 1'b0, clr = 1'b1, due = 1'b0;
  logic trig, thr, zc, tx1, tx2, rx2, start, stop, fault_n, tx1_q, stop_q;
  logic [7:0] tx1_n, tx2_n, stop_n, start_n, wcnt, alt_bad;
  logic [7:0] obs [0:8];
  uts_note_s notes [$];
  uts_note_s nt;
  int n_errors = 0, n_compared = 0, cycles = 0, seed = 7802, i;
  uts_sequencer uts_sequencer_inst (.i_clk(i_clk), .i_rst(i_rst), .i_enable(i_enable), .i_trigger(trig),
    .i_channel_pin(i_channel_pin), .i_threshold_event(thr), .i_zero_cross(zc), .i_reg_write(i_reg_write),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_transmit_port_one(tx1),
    .o_transmit_port_two(tx2), .o_receive_select_two(rx2), .o_start(start), .o_stop(stop), .o_fault_pin_n(fault_n));
  uts_host_model uts_host_model_inst (.i_clk(i_clk), .i_falling(falling), .i_fire(fire), .i_echo(echo),
    .i_slow(slow), .o_trigger(trig), .o_threshold_event(thr), .o_zero_cross(zc));
  always #25 i_clk = ~i_clk;
  assign obs = '{o_reg_rdata, tx1_n, tx2_n, stop_n, start_n, wcnt, {7'h00, fault_n}, alt_bad, {7'h00, rx2}};
  // Observed counts; wcnt holds the width of the first transmit pulse.
  always @(posedge i_clk) begin
    tx1_q <= tx1;
    stop_q <= stop;
    cycles <= cycles + 1;
    if (clr) begin
      {tx1_n, tx2_n, stop_n, start_n, wcnt, alt_bad} <= 48'h0;
    end else begin
      tx1_n <= tx1_n + {7'h00, tx1 && !tx1_q};
      tx2_n <= tx2_n + {7'h00, tx2};
      stop_n <= stop_n + {7'h00, stop && !stop_q};
      start_n <= start_n + {7'h00, start};
      wcnt <= wcnt + {7'h00, tx1 && (tx1_n == 8'h00 || (tx1_n == 8'h01 && tx1_q))};
      alt_bad <= alt_bad + {7'h00, tx1 && rx2};
    end
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end
  // Monitor: oldest note against what the outputs show now.
  always @(negedge i_clk) begin
    if (due) begin
      nt = notes.pop_front();
      check(nt.what, nt.exp & nt.mask, obs[nt.src] & nt.mask);
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic expect_val(input string what, input int src, input logic [7:0] exp, input logic [7:0] mask);
    notes.push_back('{what, src, exp, mask});
    due <= 1'b1;
    @(posedge i_clk);
    due <= 1'b0;
    @(posedge i_clk);
  endtask : expect_val
  task automatic rd(input logic [3:0] addr, input logic [7:0] exp, input logic [7:0] mask, input string what);
    i_reg_addr <= addr;
    @(posedge i_clk);
    expect_val(what, 0, exp, mask);
  endtask : rd
  task automatic wr(input logic [3:0] addr, input logic [7:0] data);
    i_reg_addr <= addr;
    i_reg_wdata <= data;
    i_reg_write <= 1'b1;
    @(posedge i_clk);
    i_reg_write <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic ask(input logic want_echo);
    echo <= want_echo;
    fire <= !want_echo;
    @(posedge i_clk);
    echo <= 1'b0;
    fire <= 1'b0;
    @(posedge i_clk);
  endtask : ask
  task automatic wait_obs(input int src, input logic [7:0] val, input int lim);
    for (int k = 0; k < lim && obs[src] !== val; k++) @(posedge i_clk);
  endtask : wait_obs
  task automatic restart(input logic en);
    i_rst <= 1'b1;
    i_enable <= en;
    falling <= 1'b0;
    clr <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    clr <= 1'b0;
    repeat (80) @(posedge i_clk);
  endtask : restart
  task automatic summarize;
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  initial begin
    restart(1'b0);
    rd(uts_pkg::FAULT_ADDR, ST_SLEEP, 8'h1C, "state_sleep");
    rd(uts_pkg::TRANSMIT_CONFIG_ADDR, uts_pkg::TRANSMIT_CONFIG_RST, 8'hFF, "tx_config");
    rd(uts_pkg::SHAPE_CONFIG_ADDR, uts_pkg::SHAPE_CONFIG_RST, 8'hFF, "shape_config");
    rd(4'(5 + {$random(seed)} % 11), 8'h00, 8'hFF, "unmapped");
    restart(1'b1);
    rd(uts_pkg::FAULT_ADDR, ST_READY, 8'h1C, "state_ready");
    ask(1'b0);
    wait_obs(4, 8'h01, 300);
    expect_val("starts", 4, 8'h01, 8'hFF);
    wait_obs(6, 8'h00, 6000);
    expect_val("tx1_pulses", 1, 8'h05, 8'hFF);
    expect_val("tx2_cycles", 2, 8'h00, 8'hFF);
    expect_val("rx_in_burst", 7, 8'h00, 8'hFF);
    expect_val("fault_pin", 6, 8'h00, 8'hFF);
    rd(uts_pkg::FAULT_ADDR, ST_READY | 8'h01, 8'h1D, "timeout_flags");
    wr(uts_pkg::FAULT_ADDR, 8'h03);
    expect_val("fault_released", 6, 8'h01, 8'hFF);
    rd(uts_pkg::FAULT_ADDR, ST_SLEEP, 8'h1F, "after_clear");
    restart(1'b1);
    slow <= 1'({$random(seed)});
    i_channel_pin <= 1'({$random(seed)});
    ask(1'b0);
    wait_obs(4, 8'h01, 300);
    repeat (150) @(posedge i_clk);
    expect_val("rx_listen", 8, 8'h01, 8'hFF);
    ask(1'b1);
    wait_obs(3, 8'h01, 100);
    repeat (40) @(posedge i_clk);
    expect_val("stops", 3, 8'h01, 8'hFF);
    expect_val("no_fault", 6, 8'h01, 8'hFF);
    rd(uts_pkg::FAULT_ADDR, ST_SLEEP, 8'h1F, "mode0_done");
    restart(1'b1);
    wr(uts_pkg::SHAPE_CONFIG_ADDR, 8'h5F);
    falling <= 1'b1;
    repeat (100) @(posedge i_clk);
    expect_val("rising_ignored", 4, 8'h00, 8'hFF);
    ask(1'b0);
    wait_obs(4, 8'h01, 300);
    expect_val("falling_start", 4, 8'h01, 8'hFF);
    repeat (20) @(posedge i_clk);
    i_enable <= 1'b0;
    repeat (20) @(posedge i_clk);
    rd(uts_pkg::FAULT_ADDR, ST_SLEEP, 8'h1F, "abort_sleep");
    for (i = 0; i < 4; i++) begin
      restart(1'b1);
      wr(uts_pkg::MEAS_CONFIG_ADDR, MCFG[i]);
      wr(uts_pkg::TRANSMIT_CONFIG_ADDR, TCFG[i]);
      wr(uts_pkg::SHAPE_CONFIG_ADDR, SCFG[i]);
      ask(1'b0);
      wait_obs(4, 8'h01, 300);
      repeat (300) @(posedge i_clk);
      expect_val("burst_pulses", 1, NTX[i], 8'hFF);
      expect_val("half_period", 5, HALF[i], 8'hFF);
      expect_val("tx2_cycles", 2, TX2C[i], 8'hFF);
      expect_val("rx_listen", 8, RXL[i], 8'hFF);
    end
    summarize();
  end
endmodule : tb_ultrasonic_tof_sequencer

/* dv/uts_host_model.sv */
// Purpose: Stopwatch-side model: issues triggers and plays one echo.
// Assumes: Shares the bench clock; the bench paces requests.
// Notes: The echo comes promptly or late as asked.
`timescale 1ns/1ps
module uts_host_model (
  input wire logic i_clk,
  input wire logic i_falling,
  input wire logic i_fire,
  input wire logic i_echo,
  input wire logic i_slow,
  output logic o_trigger,
  output logic o_threshold_event,
  output logic o_zero_cross
);
  logic [3:0] trig_cnt = 4'h0; // Cycles left in the trigger pulse.
  logic [4:0] echo_cnt = 5'h00; // Countdown through the echo shape.
  // Countdowns run only on request, so the lines idle between measurements.
  always @(posedge i_clk) begin
    if (i_fire) begin
      trig_cnt <= 4'h4;
    end else if (trig_cnt != 4'h0) begin
      trig_cnt <= trig_cnt - 4'h1;
    end
    if (i_echo) begin
      echo_cnt <= i_slow ? 5'h1F : 5'h14;
    end else if (echo_cnt != 5'h00) begin
      echo_cnt <= echo_cnt - 5'h01;
    end
  end
  assign o_trigger = i_falling ^ (trig_cnt != 4'h0);
  assign o_threshold_event = (echo_cnt >= 5'h10) && (echo_cnt <= 5'h12);
  assign o_zero_cross = (echo_cnt >= 5'h08) && (echo_cnt <= 5'h0B);
endmodule : uts_host_model

/* dv/uts_sequencer_chk.sv */
// Purpose: Port-level checker for the sequencer.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Bound to the sequencer at the foot of this file.
`timescale 1ns/1ps
module uts_sequencer_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_trigger,
  input wire logic i_zero_cross,
  input wire logic i_reg_write,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic o_transmit_port_one,
  input wire logic o_transmit_port_two,
  input wire logic o_start,
  input wire logic o_stop,
  input wire logic o_fault_pin_n
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic trig_q; // Trigger level one cycle ago.
  logic zc_q; // Zero-cross level one cycle ago.
  logic [7:0] since_trig; // Saturating cycles since the trigger pin moved.
  logic [7:0] since_zc; // Saturating cycles since a rising crossing.
  // Counters saturate so that long idle spells never wrap to a small value.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      trig_q <= 1'b0;
      zc_q <= 1'b0;
      since_trig <= 8'hFF;
      since_zc <= 8'hFF;
    end else begin
      trig_q <= i_trigger;
      zc_q <= i_zero_cross;
      since_trig <= (i_trigger != trig_q) ? 8'h00 : since_trig + {7'h00, since_trig != 8'hFF};
      since_zc <= (i_zero_cross && !zc_q) ? 8'h00 : since_zc + {7'h00, since_zc != 8'hFF};
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_start_pulse; o_start |=> !o_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_start_lead; o_start |-> since_trig >= 8'h08; endproperty
  a_start_lead: assert property (p_start_lead) else $error("start too soon after trigger");
  property p_tx_one_side; !(o_transmit_port_one && o_transmit_port_two); endproperty
  a_tx_one_side: assert property (p_tx_one_side) else $error("both transmit ports driven");
  property p_rst_quiet; $fell(i_rst) |-> !o_start && !o_transmit_port_one && o_fault_pin_n; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  property p_abort; $fell(i_enable) |-> ##4 (!o_transmit_port_one && !o_transmit_port_two); endproperty
  a_abort: assert property (p_abort) else $error("burst survives enable low");
  property p_fault_clear;
    (i_reg_write && i_reg_addr == uts_pkg::FAULT_ADDR && i_reg_wdata[uts_pkg::FAULT_CLEAR_BIT]) |-> ##3 o_fault_pin_n;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault pin not released");
  property p_stop_cause; $rose(o_stop) |-> since_zc <= 8'h08; endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("stop without crossing");
  property p_fault_after_run; $fell(o_fault_pin_n) |-> since_trig >= 8'h20; endproperty
  a_fault_after_run: assert property (p_fault_after_run) else $error("fault without listening");
endmodule : uts_sequencer_chk
bind uts_sequencer uts_sequencer_chk uts_sequencer_chk_inst (.i_clk(i_clk), .i_rst(i_rst), .i_enable(i_enable),
  .i_trigger(i_trigger), .i_zero_cross(i_zero_cross), .i_reg_write(i_reg_write), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_transmit_port_one(o_transmit_port_one), .o_transmit_port_two(o_transmit_port_two),
  .o_start(o_start), .o_stop(o_stop), .o_fault_pin_n(o_fault_pin_n));

/* pkg/uts_pkg.sv */
// Purpose: Shared constants for the ultrasonic time-of-flight sequencer.
// Assumes: Registers are written through a simple parallel write port.
// Notes: Offsets are register indices on the device's own register port.
package uts_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] TRANSMIT_CONFIG_ADDR = 4'h0; // Burst divider and pulse count.
  localparam logic [3:0] MEAS_CONFIG_ADDR = 4'h1; // Mode, channel, swap, stops, echo setup.
  localparam logic [3:0] SHAPE_CONFIG_ADDR = 4'h2; // Phase flip, damping, edge, base divider.
  localparam logic [3:0] FAULT_ADDR = 4'h3; // Fault flags and state machine reset.

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BURST_DIV_LSB = 5; // Burst period divider field, bits 7 to 5.
  localparam int FAULT_CLEAR_BIT = 0; // Writing one clears the fault flags.
  localparam int FSM_RESET_BIT = 1; // Writing one resets the state machine.
  localparam logic [7:0] TRANSMIT_CONFIG_RST = 8'h45; // Divide by 8, five pulses.
  localparam logic [7:0] MEAS_CONFIG_RST = 8'h10; // Mode 0, one stop expected.
  localparam logic [7:0] SHAPE_CONFIG_RST = 8'h1F; // Phase flip disabled.
  localparam logic [4:0] PHASE_FLIP_OFF = 5'h1F; // Position that disables the flip.

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int START_BASE_PERIODS = 3; // Base periods between trigger and start.
  localparam int START_BURST_PERIODS = 2; // Least burst periods before start.
  localparam int LISTEN_BURST_PERIODS = 255; // Last listen count; the window ends after 256 burst periods.

  // Mode encodings.
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;

  // Sequencer states.
  typedef enum logic [2:0] {
    UTS_POWERUP, UTS_SLEEP, UTS_READY, UTS_ALIGN, UTS_BURST, UTS_LISTEN
  } uts_state_e;

endpackage : uts_pkg
